/* design/mdp_map.vh */
// Register map, field layout and reset values of the parameter block.
// Included by the parameter controller; holds definitions only.
`ifndef MDP_MAP_VH
`define MDP_MAP_VH
`define MDP_ADDR_W 8
`define MDP_OFF_STOP_ACT 8'h00
`define MDP_OFF_OT_ACT 8'h04
`define MDP_OFF_HOME_DIR 8'h08
`define MDP_OFF_DEV_ALARM 8'h0c
`define MDP_OFF_DEV_WARN 8'h10
`define MDP_OFF_MODE 8'h14
`define MDP_OFF_POS_GAIN 8'h18
`define MDP_OFF_HOME_ACC 8'h1c
`define MDP_OFF_STATUS 8'h20
`define MDP_OFF_IRQ_STAT 8'h24
`define MDP_OFF_IRQ_MASK 8'h28
`define MDP_RST_STOP_ACT 2'h0
`define MDP_RST_OT_ACT 1'h0
`define MDP_RST_HOME_DIR 1'h1
`define MDP_RST_DEV_ALARM 15'h07d0
`define MDP_RST_DEV_WARN 15'h07d0
`define MDP_RST_MODE 3'h0
`define MDP_RST_POS_GAIN 7'h07
`define MDP_RST_HOME_ACC 15'h0064
`define MDP_RST_IRQ_MASK 3'h0
`define MDP_THR_MIN 15'h0001
`define MDP_THR_MAX 15'h7530
`define MDP_STEPS_PER_CREV 3'h5
`define MDP_MODE_POS_BIT 0
`define MDP_MODE_HOLD_BIT 1
`define MDP_MODE_LEGACY_BIT 2
`define MDP_IRQ_ALARM_BIT 0
`define MDP_IRQ_WARN_BIT 1
`define MDP_IRQ_STOP_BIT 2
`define MDP_STAT_SPARE_BIT 0
`define MDP_STAT_IRQ_BIT 1
`define MDP_STAT_STOP_LSB 2
`define MDP_STAT_OT_BIT 4
`define MDP_STAT_HDIR_BIT 5
`define MDP_STAT_MODE_LSB 6
`define MDP_STAT_RUN_BIT 9
`define MDP_STAT_ALARM_BIT 10
`define MDP_STAT_WARN_BIT 11
`define MDP_STOP_IMM 2'h0
`define MDP_STOP_DEC 2'h1
`define MDP_STOP_IMM_OFF 2'h2
`define MDP_STOP_DEC_OFF 2'h3
`define MDP_NV_WORDS 8
`endif

/* design/mdp_param_ctrl.v */
// Parameter store, stop reaction and deviation monitor of a motor driver.
// Assumes one 50 MHz clock, synchronous inputs and a plain register port.
//
// Overview of operation
// - Every written parameter is also kept in storage surviving power loss.
// - Immediate-class parameters apply in the cycle after their write.
// - Stop-class parameters apply only once the motor is not running.
// - Power-cycle-class parameters apply only after the next reset.
// - Stop reaction codes 0..3: immediate, decelerate, each optionally current off.
// - Speed control without hold: 0,2 immediate; 1,3 decelerating stop.
// - One step equals 0.72 degrees, so 500 steps per revolution.
// - Alarm when deviation exceeds threshold of 0.01..300.00 rev, default 20.00.
// - Position control only: warning on its own threshold, default 20.00.
// - Speed control: gain and filters act only when servo hold selected.
// - Home seeking starts negative for 0, positive for 1; default 1.
// - Home acceleration setting has no effect in legacy mode.
`timescale 1ns/100ps
`include "mdp_map.vh"
module mdp_param_ctrl (
   // Clock, reset, enable
   input wire i_clock,
   input wire i_reset,
   input wire i_clock_enable,
   // Register port
   input wire [7:0] i_addr,
   input wire [31:0] i_wdata,
   input wire i_write,
   input wire i_read,
   output reg [31:0] o_rdata,
   // Storage and motor status
   input wire i_nv_ok,
   input wire i_motor_running,
   input wire i_stop_req,
   input wire i_overtravel,
   input wire [23:0] i_deviation,
   // Motor control outputs
   output reg o_stop_immediate,
   output reg o_stop_decel,
   output reg o_current_off,
   output reg o_home_dir_pos,
   output reg [14:0] o_home_accel,
   output reg o_home_accel_en,
   output reg [6:0] o_pos_gain,
   output reg o_loop_filters_en,
   output reg o_alarm,
   output reg o_warning,
   // Interrupt
   output wire o_irq
);
   // Storage image; no reset so its contents outlive i_reset
   reg [14:0] nv_mem [0:`MDP_NV_WORDS-1];
   // Written (pending) values
   // Reads return these, not the applied copies
   reg [1:0] stop_act_reg;
   reg ot_act_reg;
   reg home_dir_reg;
   reg [14:0] dev_alarm_reg;
   reg [14:0] dev_warn_reg;
   reg [2:0] mode_reg;
   reg [6:0] pos_gain_reg;
   reg [14:0] home_acc_reg;
   // Applied values
   reg [1:0] stop_act_app_reg;
   reg ot_act_app_reg;
   reg home_dir_app_reg;
   reg [2:0] mode_app_reg;
   reg [2:0] irq_stat_reg;
   reg [2:0] irq_mask_reg;
   reg stop_prev_reg;
   reg [2:0] irq_set;
   reg [31:0] rdata_next;
   reg [1:0] stop_eff;
   wire wr_stop = i_write && (i_addr == `MDP_OFF_STOP_ACT);
   wire wr_ot = i_write && (i_addr == `MDP_OFF_OT_ACT);
   wire wr_home = i_write && (i_addr == `MDP_OFF_HOME_DIR);
   wire wr_alarm = i_write && (i_addr == `MDP_OFF_DEV_ALARM);
   wire wr_warn = i_write && (i_addr == `MDP_OFF_DEV_WARN);
   wire wr_mode = i_write && (i_addr == `MDP_OFF_MODE);
   wire wr_gain = i_write && (i_addr == `MDP_OFF_POS_GAIN);
   wire wr_hacc = i_write && (i_addr == `MDP_OFF_HOME_ACC);
   wire wr_istat = i_write && (i_addr == `MDP_OFF_IRQ_STAT);
   wire wr_imask = i_write && (i_addr == `MDP_OFF_IRQ_MASK);
   wire [14:0] thr_in = i_wdata[14:0];
   // Out-of-range thresholds are clamped rather than dropped
   wire [14:0] thr_clamp = (thr_in < `MDP_THR_MIN) ? `MDP_THR_MIN :
      (thr_in > `MDP_THR_MAX) ? `MDP_THR_MAX : thr_in;
   // Threshold in 0.01 rev times 5 steps gives steps
   wire [23:0] alarm_steps = {9'h000, dev_alarm_reg} * {21'h000000, `MDP_STEPS_PER_CREV};
   wire [23:0] warn_steps = {9'h000, dev_warn_reg} * {21'h000000, `MDP_STEPS_PER_CREV};
   wire pos_mode = mode_app_reg[`MDP_MODE_POS_BIT];
   wire hold = mode_app_reg[`MDP_MODE_HOLD_BIT];
   wire legacy = mode_app_reg[`MDP_MODE_LEGACY_BIT];
   // Strictly above; a deviation equal to the threshold is still in range
   wire alarm_now = i_deviation > alarm_steps;
   wire warn_now = pos_mode && (i_deviation > warn_steps);
   wire stop_edge = i_stop_req && !stop_prev_reg;
   // Immediate class: a write reaches the outputs at its own edge, no extra cycle
   wire [6:0] gain_now = wr_gain ? i_wdata[6:0] : pos_gain_reg;
   wire [14:0] hacc_now = wr_hacc ? i_wdata[14:0] : home_acc_reg;
   // Write-one-to-clear mask for the sticky status
   wire [2:0] irq_clr = wr_istat ? i_wdata[2:0] : 3'h0;

   // Status word, read-only
   wire [11:0] status_word;
   assign status_word[`MDP_STAT_SPARE_BIT] = 1'b0;
   assign status_word[`MDP_STAT_IRQ_BIT] = o_irq;
   assign status_word[`MDP_STAT_STOP_LSB +: 2] = stop_act_app_reg;
   assign status_word[`MDP_STAT_OT_BIT] = ot_act_app_reg;
   assign status_word[`MDP_STAT_HDIR_BIT] = home_dir_app_reg;
   assign status_word[`MDP_STAT_MODE_LSB +: 3] = mode_app_reg;
   assign status_word[`MDP_STAT_RUN_BIT] = i_motor_running;
   assign status_word[`MDP_STAT_ALARM_BIT] = o_alarm;
   assign status_word[`MDP_STAT_WARN_BIT] = o_warning;

   // Written values; reset restores from storage when it is valid
   always @(posedge i_clock) begin
      if (i_reset) begin
         stop_act_reg <= i_nv_ok ? nv_mem[0][1:0] : `MDP_RST_STOP_ACT;
         ot_act_reg <= i_nv_ok ? nv_mem[1][0] : `MDP_RST_OT_ACT;
         home_dir_reg <= i_nv_ok ? nv_mem[2][0] : `MDP_RST_HOME_DIR;
         dev_alarm_reg <= i_nv_ok ? nv_mem[3] : `MDP_RST_DEV_ALARM;
         dev_warn_reg <= i_nv_ok ? nv_mem[4] : `MDP_RST_DEV_WARN;
         mode_reg <= i_nv_ok ? nv_mem[5][2:0] : `MDP_RST_MODE;
         pos_gain_reg <= i_nv_ok ? nv_mem[6][6:0] : `MDP_RST_POS_GAIN;
         home_acc_reg <= i_nv_ok ? nv_mem[7] : `MDP_RST_HOME_ACC;
      end else if (i_clock_enable) begin
         if (wr_stop) begin
            stop_act_reg <= i_wdata[1:0];
         end
         if (wr_ot) begin
            ot_act_reg <= i_wdata[0];
         end
         if (wr_home) begin
            home_dir_reg <= i_wdata[0];
         end
         if (wr_alarm) begin
            dev_alarm_reg <= thr_clamp;
         end
         if (wr_warn) begin
            dev_warn_reg <= thr_clamp;
         end
         if (wr_mode) begin
            mode_reg <= i_wdata[2:0];
         end
         if (wr_gain) begin
            pos_gain_reg <= i_wdata[6:0];
         end
         if (wr_hacc) begin
            home_acc_reg <= i_wdata[14:0];
         end
      end
   end

   // Storage image follows every parameter write
   always @(posedge i_clock) begin
      if (i_clock_enable) begin
         if (wr_stop) begin
            nv_mem[0] <= {13'h0000, i_wdata[1:0]};
         end
         if (wr_ot) begin
            nv_mem[1] <= {14'h0000, i_wdata[0]};
         end
         if (wr_home) begin
            nv_mem[2] <= {14'h0000, i_wdata[0]};
         end
         if (wr_alarm) begin
            nv_mem[3] <= thr_clamp;
         end
         if (wr_warn) begin
            nv_mem[4] <= thr_clamp;
         end
         if (wr_mode) begin
            nv_mem[5] <= {12'h000, i_wdata[2:0]};
         end
         if (wr_gain) begin
            nv_mem[6] <= {8'h00, i_wdata[6:0]};
         end
         if (wr_hacc) begin
            nv_mem[7] <= i_wdata[14:0];
         end
      end
   end

   // Applied copies of deferred classes
   always @(posedge i_clock) begin
      if (i_reset) begin
         stop_act_app_reg <= i_nv_ok ? nv_mem[0][1:0] : `MDP_RST_STOP_ACT;
         ot_act_app_reg <= i_nv_ok ? nv_mem[1][0] : `MDP_RST_OT_ACT;
         home_dir_app_reg <= i_nv_ok ? nv_mem[2][0] : `MDP_RST_HOME_DIR;
         // Mode waits for the next reset: it reshapes the whole loop
         mode_app_reg <= i_nv_ok ? nv_mem[5][2:0] : `MDP_RST_MODE;
      end else if (i_clock_enable) begin
         // Changing reaction mid-move could strand a half-done stop
         if (!i_motor_running) begin
            stop_act_app_reg <= stop_act_reg;
            ot_act_app_reg <= ot_act_reg;
            home_dir_app_reg <= home_dir_reg;
         end
      end
   end

   // Stop reaction code after control-mode folding
   always @* begin
      stop_eff = stop_act_app_reg;
      if (!pos_mode && !hold) begin
         stop_eff = {1'b0, stop_act_app_reg[0]};
      end
   end

   // Motor control outputs
   always @(posedge i_clock) begin
      if (i_reset) begin
         stop_prev_reg <= 1'b0;
         o_stop_immediate <= 1'b0;
         o_stop_decel <= 1'b0;
         o_current_off <= 1'b0;
         o_home_dir_pos <= `MDP_RST_HOME_DIR;
         o_home_accel <= 15'h0000;
         o_home_accel_en <= 1'b0;
         o_pos_gain <= 7'h00;
         o_loop_filters_en <= 1'b0;
         o_alarm <= 1'b0;
         o_warning <= 1'b0;
      end else if (i_clock_enable) begin
         stop_prev_reg <= i_stop_req;
         // Stop input outranks overtravel
         if (i_stop_req) begin
            o_stop_immediate <= !stop_eff[0];
            o_stop_decel <= stop_eff[0];
            o_current_off <= stop_eff[1];
         end else if (i_overtravel) begin
            o_stop_immediate <= !ot_act_app_reg;
            o_stop_decel <= ot_act_app_reg;
            o_current_off <= 1'b0;
         end else begin
            o_stop_immediate <= 1'b0;
            o_stop_decel <= 1'b0;
            o_current_off <= 1'b0;
         end
         o_home_dir_pos <= home_dir_app_reg;
         o_home_accel_en <= !legacy;
         o_home_accel <= legacy ? 15'h0000 : hacc_now;
         o_loop_filters_en <= pos_mode || hold;
         o_pos_gain <= (pos_mode || hold) ? gain_now : 7'h00;
         o_alarm <= alarm_now;
         o_warning <= warn_now;
      end
   end

   // Event sources for the sticky status
   always @* begin
      irq_set = 3'h0;
      irq_set[`MDP_IRQ_ALARM_BIT] = alarm_now && !o_alarm;
      irq_set[`MDP_IRQ_WARN_BIT] = warn_now && !o_warning;
      irq_set[`MDP_IRQ_STOP_BIT] = stop_edge;
   end

   // Sticky status, write one to clear; a new event wins
   always @(posedge i_clock) begin
      if (i_reset) begin
         irq_stat_reg <= 3'h0;
         irq_mask_reg <= `MDP_RST_IRQ_MASK;
      end else if (i_clock_enable) begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
         if (wr_imask) begin
            irq_mask_reg <= i_wdata[2:0];
         end
      end
   end

   // Level output; stays high until software clears or masks the event
   assign o_irq = |(irq_stat_reg & irq_mask_reg);

   // Read mux; unmapped offsets read zero
   always @* begin
      rdata_next = 32'h00000000;
      case (i_addr)
         `MDP_OFF_STOP_ACT: rdata_next[1:0] = stop_act_reg;
         `MDP_OFF_OT_ACT: rdata_next[0] = ot_act_reg;
         `MDP_OFF_HOME_DIR: rdata_next[0] = home_dir_reg;
         `MDP_OFF_DEV_ALARM: rdata_next[14:0] = dev_alarm_reg;
         `MDP_OFF_DEV_WARN: rdata_next[14:0] = dev_warn_reg;
         `MDP_OFF_MODE: rdata_next[2:0] = mode_reg;
         `MDP_OFF_POS_GAIN: rdata_next[6:0] = pos_gain_reg;
         `MDP_OFF_HOME_ACC: rdata_next[14:0] = home_acc_reg;
         `MDP_OFF_STATUS: rdata_next[11:0] = status_word;
         `MDP_OFF_IRQ_STAT: rdata_next[2:0] = irq_stat_reg;
         `MDP_OFF_IRQ_MASK: rdata_next[2:0] = irq_mask_reg;
         default: rdata_next = 32'h00000000;
      endcase
   end

   always @(posedge i_clock) begin
      if (i_reset) begin
         o_rdata <= 32'h00000000;
      end else if (i_clock_enable) begin
         // One cycle only, so a stale word never looks fresh
         o_rdata <= i_read ? rdata_next : 32'h00000000;
      end
   end
endmodule // mdp_param_ctrl

/* verification/mdp_checker.sv */
// Port checker of the parameter controller, bound into each instance.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`include "mdp_map.vh"
module mdp_checker (
   // Clock and register port
   input wire i_clock, i_reset, i_clock_enable, i_write, i_read,
   input wire [7:0] i_addr,
   input wire [31:0] i_wdata, o_rdata,
   // Motor side
   input wire i_stop_req, i_overtravel, o_stop_immediate, o_stop_decel, o_current_off,
   input wire [23:0] i_deviation,
   input wire o_home_accel_en, o_loop_filters_en, o_alarm, o_warning,
   input wire [14:0] o_home_accel,
   input wire [6:0] o_pos_gain
);
   reg [6:0] gain_q;
   always @(posedge i_clock) begin
      gain_q <= i_wdata[6:0];
   end
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);
   // Gain values outside 1..100 may be clamped, so left out
   sequence s_gain_wr;
      i_clock_enable && i_write && i_addr == `MDP_OFF_POS_GAIN
         && i_wdata < 32'd101 && i_wdata != 32'd0;
   endsequence
   a_rdata_idle_zero: assert property ($past(i_clock_enable) && !$past(i_read) |-> o_rdata == 0)
      else $error("read data outside read slot");
   a_stop_on_req: assert property (i_clock_enable && i_stop_req |=> o_stop_immediate || o_stop_decel)
      else $error("stop input without stop action");
   a_stop_release: assert property (i_clock_enable && !i_stop_req && !i_overtravel
      |=> !(o_stop_immediate || o_stop_decel || o_current_off)) else $error("stop without cause");
   a_stop_exclusive: assert property (!(o_stop_immediate && o_stop_decel))
      else $error("both stop kinds at once");
   a_travel_no_off: assert property (i_clock_enable && i_overtravel && !i_stop_req
      |=> !o_current_off && (o_stop_immediate || o_stop_decel)) else $error("overtravel action");
   a_alarm_cause: assert property ($rose(o_alarm) |-> $past(i_deviation) > 24'h5)
      else $error("alarm below smallest threshold");
   a_warn_cause: assert property ($rose(o_warning) |-> $past(i_deviation) > 24'h5)
      else $error("warning below smallest threshold");
   a_gain_gated: assert property (!o_loop_filters_en |-> o_pos_gain == 7'h0)
      else $error("gain active while loop disabled");
   a_accel_gated: assert property (!o_home_accel_en |-> o_home_accel == 15'h0)
      else $error("home accel active in legacy mode");
   a_gain_write: assert property (s_gain_wr ##1 o_loop_filters_en |-> o_pos_gain == gain_q)
      else $error("gain not applied at once");
endmodule // mdp_checker
bind mdp_param_ctrl mdp_checker chk_i (.i_clock(i_clock), .i_reset(i_reset),
   .i_clock_enable(i_clock_enable), .i_write(i_write), .i_read(i_read), .i_addr(i_addr),
   .i_wdata(i_wdata), .o_rdata(o_rdata), .i_stop_req(i_stop_req), .i_overtravel(i_overtravel),
   .o_stop_immediate(o_stop_immediate), .o_stop_decel(o_stop_decel),
   .o_current_off(o_current_off), .i_deviation(i_deviation), .o_home_accel_en(o_home_accel_en),
   .o_loop_filters_en(o_loop_filters_en), .o_alarm(o_alarm), .o_warning(o_warning),
   .o_home_accel(o_home_accel), .o_pos_gain(o_pos_gain));

/* verification/mdp_motor_model.sv */
// Motor stand-in: runs on a start pulse, halts on any stop output.
// Assumes the controller clock; deviation follows the bench setting.
`timescale 1ns/100ps
module mdp_motor_model (
   // Clock and bench commands
   input wire i_clock,
   input wire i_start,
   input wire [23:0] i_dev_set,
   // Controller stop outputs
   input wire i_stop_immediate,
   input wire i_stop_decel,
   // Motor state
   output reg o_running = 1'b0,
   output reg [23:0] o_deviation = 24'h0
);
   // Halts at once even for a decelerating stop: the harsher case
   always @(posedge i_clock) begin
      o_running <= i_start | (o_running & ~i_stop_immediate & ~i_stop_decel);
      o_deviation <= i_dev_set;
   end
endmodule // mdp_motor_model

/* verification/tb.sv */
// Bench for the parameter controller: register calls and motor stimulus.
// Assumes the controller, the motor stand-in and the checker compile first.
`timescale 1ns/100ps
module tb;
   reg i_clock = 1'b0, i_reset = 1'b1, i_write = 1'b0, i_read = 1'b0, i_nv_ok = 1'b0;
   reg stop_req = 1'b0, ot = 1'b0, go = 1'b0, ce = 1'b1;
   reg [7:0] i_addr = 8'h00;
   reg [31:0] i_wdata = 32'h0;
   reg [23:0] dev = 24'h0;
   wire run, imm, dec, off, hdir, hen, fen, alm, wrn, irq;
   wire [31:0] rdata;
   wire [23:0] devq;
   wire [14:0] hacc;
   wire [6:0] gain;
   wire [2:0] stp = {imm, dec, off};
   integer n_mismatch = 0, checks = 0, k;
   always #10 i_clock = ~i_clock;
   mdp_param_ctrl dut (.i_clock(i_clock), .i_reset(i_reset), .i_clock_enable(ce),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .o_rdata(rdata),
      .i_nv_ok(i_nv_ok), .i_motor_running(run), .i_stop_req(stop_req), .i_overtravel(ot),
      .i_deviation(devq), .o_stop_immediate(imm), .o_stop_decel(dec), .o_current_off(off),
      .o_home_dir_pos(hdir), .o_home_accel(hacc), .o_home_accel_en(hen), .o_pos_gain(gain),
      .o_loop_filters_en(fen), .o_alarm(alm), .o_warning(wrn), .o_irq(irq));
   mdp_motor_model motor (.i_clock(i_clock), .i_start(go), .i_dev_set(dev),
      .i_stop_immediate(imm), .i_stop_decel(dec), .o_running(run), .o_deviation(devq));
   task conclude;
      if (n_mismatch == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input [31:0] g, input [31:0] e);
      checks = checks + 1;
      if (g !== e) begin
         n_mismatch = n_mismatch + 1;
         $display("Error at %0t: got %h, expected %h", $time, g, e);
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      @(posedge i_clock);
      i_write <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_write <= 1'b0;
      @(negedge i_clock);
   endtask
   task rdc(input [7:0] a, input [31:0] e);
      @(posedge i_clock);
      i_read <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_read <= 1'b0;
      @(negedge i_clock);
      chk(rdata, e);
   endtask
   task drv(input s, input o, input [23:0] d);
      @(posedge i_clock);
      stop_req <= s;
      ot <= o;
      dev <= d;
      repeat (2) @(posedge i_clock);
      @(negedge i_clock);
   endtask
   task rst(input nv);
      @(posedge i_clock);
      i_reset <= 1'b1;
      i_nv_ok <= nv;
      repeat (10) @(posedge i_clock);
      i_reset <= 1'b0;
      // One enabled edge so the outputs leave their reset values
      @(posedge i_clock);
      @(negedge i_clock);
   endtask
   task stopc(input [31:0] c, input [2:0] e);
      wr(8'h00, c);
      drv(1'b1, 1'b0, 24'h0);
      chk({29'h0, stp}, {29'h0, e});
      drv(1'b0, 1'b0, 24'h0);
   endtask
   task devc(input [23:0] d, input [1:0] e);
      drv(1'b0, 1'b0, d);
      chk({30'h0, alm, wrn}, {30'h0, e});
   endtask
   initial begin
      rst(1'b0);
      chk({15'h0, hdir, hen, hacc}, 32'h18064);
      chk({24'h0, fen, gain}, 32'h0);
      rdc(8'h00, 32'h0);
      rdc(8'h04, 32'h0);
      rdc(8'h0c, 32'h7d0);
      rdc(8'h10, 32'h7d0);
      rdc(8'h30, 32'h0);
      // A write while the enable is low must leave no trace
      @(posedge i_clock);
      ce <= 1'b0;
      wr(8'h1c, 32'h5);
      chk({17'h0, hacc}, 32'h64);
      @(posedge i_clock);
      ce <= 1'b1;
      rdc(8'h1c, 32'h64);
      // Storage image is unknown until every word has been written
      for (k = 0; k < 8; k = k + 1) begin
         wr(8'(4 * k), {24'h0, 8'(64'h64_09_03_04_02_00_01_01 >> (8 * k))});
      end
      chk({30'h0, hdir, fen}, 32'h0);
      rst(1'b1);
      chk({23'h0, hdir, fen, gain}, 32'h89);
      rdc(8'h20, 32'hd4);
      rdc(8'h0c, 32'h2);
      wr(8'h18, 32'hc);
      chk({25'h0, gain}, 32'hc);
      for (k = 0; k < 4; k = k + 1) begin
         stopc(k, {~k[0], k[0], k[1]});
      end
      drv(1'b0, 1'b1, 24'h0);
      chk({29'h0, stp}, 32'h2);
      drv(1'b0, 1'b0, 24'h0);
      @(posedge i_clock);
      go <= 1'b1;
      @(posedge i_clock);
      go <= 1'b0;
      wr(8'h00, 32'h0);
      drv(1'b1, 1'b0, 24'h0);
      chk({29'h0, stp}, 32'h3);
      drv(1'b1, 1'b0, 24'h0);
      chk({29'h0, stp}, 32'h4);
      devc(24'hb, 2'h2);
      devc(24'h15, 2'h3);
      devc(24'ha, 2'h0);
      chk({31'h0, irq}, 32'h0);
      rdc(8'h24, 32'h7);
      wr(8'h28, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr(8'h24, 32'h7);
      chk({31'h0, irq}, 32'h0);
      wr(8'h14, 32'h4);
      rst(1'b1);
      chk({16'h0, hen, hacc}, 32'h0);
      chk({24'h0, fen, gain}, 32'h0);
      for (k = 2; k < 4; k = k + 1) begin
         stopc(k, {~k[0], k[0], 1'b0});
      end
      devc(24'h15, 2'h2);
      conclude;
   end
endmodule // tb
